/* File: bench/test_nrd_regs.sv */
// testbench for the nvm ready flag, read value and target location register slice
// assumes nrd_regs answers each avalon-mm request after one wait cycle
`timescale 1ns/10ps
module test_nrd_regs;
    import nrd_pkg::*;
    // =====================================================
    // stimulus and observation signals
    logic ref_clk_in = 1'b0; // 100 MHz system clock
    logic rst_in = 1'b1; // held for 16 cycles
    logic [7:0] adr = 8'h00; // bus request, changed only after an edge
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h00000000;
    logic [31:0] rdata;
    logic wreq;
    logic busy = 1'b0; // programming engine level
    logic done = 1'b0; // one-cycle capture strobe
    logic ee = 1'b0; // capture is an eeprom access
    logic [15:0] val = 16'h0000; // value from memory
    logic rdy_irq;
    logic ev_irq;
    logic [23:0] loc;
    logic [31:0] exp_q[$]; // read results still awaited by the monitor
    int bad_count = 0;
    int samples_checked = 0;
    logic [15:0] dv;
    logic [23:0] av;
    // the data pair shares the flag word; its low half reads the idle flag
    localparam logic [7:0] DATA_WORD = {NRD_DATA_OFS[7:2], 2'b00};
    // =====================================================
    // clock and device
    always #5 ref_clk_in = ~ref_clk_in;
    nrd_regs uut (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .avs_address(adr),
        .avs_read(rd),
        .avs_write(wr),
        .avs_byteenable(be),
        .avs_writedata(wd),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq),
        .prog_busy_in(busy),
        .read_done_in(done),
        .eeprom_read_in(ee),
        .read_value_in(val),
        .ready_irq_out(rdy_irq),
        .event_irq_out(ev_irq),
        .target_location_out(loc)
    );
    // =====================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon transfer; request held until the edge that sees waitrequest low
    task automatic bus(input logic r, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        rd <= r;
        wr <= ~r;
        adr <= a;
        be <= b;
        wd <= d;
        do begin
            @(posedge ref_clk_in);
        end while (wreq !== 1'b0); // only the watchdog ends a hung wait
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 4'hF, 32'h00000000);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =====================================================
    // monitor: oldest note is compared whenever read data are handed over
    always @(posedge ref_clk_in) begin
        if (rd && wreq === 1'b0 && exp_q.size() > 0)
            check(rdata, exp_q.pop_front());
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        bad_count++;
        end_sim();
    end
    // =====================================================
    // main sequence
    initial begin
        void'($urandom(32'h5a2cb629));
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        // reset values, idle flag already up, unmapped place ignored
        rd_chk(NRD_CTRL_OFS, 32'h00000000);
        rd_chk(DATA_WORD, 32'h00000001);
        rd_chk(NRD_ADDR_OFS, 32'h00000000);
        rd_chk(NRD_FLAG_OFS, 32'h00000001);
        bus(1'b0, 8'h18, 4'hF, 32'hFFFFFFFF);
        rd_chk(8'h18, NRD_UNMAPPED);
        // clearing while idle does not stick, writing zero keeps
        bus(1'b0, NRD_FLAG_OFS, 4'h1, 32'h00000001);
        rd_chk(NRD_FLAG_OFS, 32'h00000001);
        bus(1'b0, NRD_FLAG_OFS, 4'h1, 32'h00000000);
        rd_chk(NRD_FLAG_OFS, 32'h00000001);
        // arming while idle raises the level request at once
        bus(1'b0, NRD_MASK_OFS, 4'h1, 32'h00000001);
        bus(1'b0, NRD_CTRL_OFS, 4'h1, 32'h00000001);
        rd_chk(NRD_CTRL_OFS, 32'h00000001);
        repeat (3) @(posedge ref_clk_in);
        check({31'h0, rdy_irq}, 32'h00000001);
        // programming drops the flag and the request, busy shows
        busy <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        check({31'h0, rdy_irq}, 32'h00000000);
        rd_chk(NRD_FLAG_OFS, 32'h00000002);
        bus(1'b0, NRD_FLAG_OFS, 4'h1, 32'h00000001);
        rd_chk(NRD_FLAG_OFS, 32'h00000002);
        busy <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        check({31'h0, rdy_irq}, 32'h00000001);
        check({31'h0, ev_irq}, 32'h00000001);
        rd_chk(NRD_STAT_OFS, 32'h00000003);
        rd_chk(NRD_STAT_OFS, 32'h00000000);
        repeat (2) @(posedge ref_clk_in);
        check({31'h0, ev_irq}, 32'h00000000);
        // handler disarms the request
        bus(1'b0, NRD_CTRL_OFS, 4'h1, 32'h00000000);
        repeat (2) @(posedge ref_clk_in);
        check({31'h0, rdy_irq}, 32'h00000000);
        // data word: both bytes, then the high byte alone
        dv = 16'($urandom);
        bus(1'b0, DATA_WORD, 4'hC, {dv, 16'hFFFF});
        rd_chk(DATA_WORD, {dv, 16'h0001});
        bus(1'b0, DATA_WORD, 4'h8, {~dv, 16'h0000});
        rd_chk(DATA_WORD, {~dv[15:8], dv[7:0], 16'h0001});
        // capture of a full word, then an eeprom byte
        val <= 16'($urandom);
        done <= 1'b1;
        @(posedge ref_clk_in);
        done <= 1'b0;
        dv = val;
        rd_chk(DATA_WORD, {dv, 16'h0001});
        val <= ~dv;
        ee <= 1'b1;
        done <= 1'b1;
        @(posedge ref_clk_in);
        done <= 1'b0;
        ee <= 1'b0;
        rd_chk(DATA_WORD, {dv[15:8], ~dv[7:0], 16'h0001});
        // address: all lanes, upper byte reads zero, then one lane at a time
        av = 24'($urandom);
        bus(1'b0, NRD_ADDR_OFS, 4'hF, {8'hFF, av});
        rd_chk(NRD_ADDR_OFS, {8'h00, av});
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, NRD_ADDR_OFS, 4'(1 << i), {8'h00, ~av});
            av[8*i +: 8] = ~av[8*i +: 8];
            rd_chk(NRD_ADDR_OFS, {8'h00, av});
        end
        check({8'h00, loc}, {8'h00, av});
        end_sim();
    end
endmodule

/* File: design/nrd_bytereg.sv */
// byte-lane writable register with a capture port
// assumes capture and bus write never meet in the same cycle unless capture wins
`timescale 1ns/10ps
module nrd_bytereg
    import nrd_pkg::*;
#(
    parameter int BYTES = 2,
    parameter logic [8*BYTES-1:0] RST = '0
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic [3:0] be_in,
    input wire logic [31:0] wdata_in,
    input wire logic cap_in,
    input wire logic [8*BYTES-1:0] cap_data_in,
    output logic [8*BYTES-1:0] q_out
);
    // elaboration check: every lane must come from one 32-bit bus word
    if (BYTES < 1 || BYTES > 4) begin : g_bad_bytes
        $error("byte count must be 1 to 4");
    end
    logic [8*BYTES-1:0] q_reg;
    logic [8*BYTES-1:0] q_next;
    // =====================================================
    // next value: hardware capture wins, else per-lane writes
    always_comb begin
        q_next = q_reg;
        if (cap_in) begin
            q_next = cap_data_in;
        end else if (wr_in) begin
            for (int i = 0; i < BYTES; i++) begin
                if (be_in[i]) begin
                    q_next[8*i +: 8] = wdata_in[8*i +: 8];
                end
            end
        end
    end
    // register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_reg <= RST;
        end else begin
            q_reg <= q_next;
        end
    end
    assign q_out = q_reg;
endmodule

/* File: design/nrd_pkg.sv */
// package for the nonvolatile ready, data and address register slice
// assumes a byte-wide view of registers packed into 32-bit avalon words
package nrd_pkg;
    // =====================================================
    // register word byte addresses
    localparam logic [7:0] NRD_CTRL_OFS = 8'h00; // enable word: ready irq enable bit only
    localparam logic [7:0] NRD_FLAG_OFS = 8'h04; // ready flag word
    localparam logic [7:0] NRD_DATA_OFS = 8'h06; // read value pair, upper half of flag word
    localparam logic [7:0] NRD_ADDR_OFS = 8'h08; // target location, lanes 0 to 2
    localparam logic [7:0] NRD_STAT_OFS = 8'h10; // sticky event status, clear on read
    localparam logic [7:0] NRD_MASK_OFS = 8'h14; // event mask
    // =====================================================
    // field positions
    localparam int NRD_READY_BIT = 0; // idle flag and its enable
    localparam int NRD_BUSY_BIT = 1; // programming indication in flag word
    localparam int NRD_EV_READY = 0; // event: programming finished
    localparam int NRD_EV_START = 1; // event: programming started
    localparam int NRD_EV_W = 2;
    // =====================================================
    // reset values
    localparam logic [15:0] NRD_DATA_RST = 16'h0000;
    localparam logic [23:0] NRD_ADDR_RST = 24'h000000;
    localparam logic [NRD_EV_W-1:0] NRD_EV_RST = 2'h0;
    localparam logic [31:0] NRD_UNMAPPED = 32'h00000000; // unmapped reads
    // =====================================================
    // bus request carrier
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } nrd_req_type;
    typedef enum logic [1:0] {
        NRD_IDLE = 2'b00,
        NRD_ANSWER = 2'b01
    } nrd_state_type;
endpackage

/* File: design/nrd_regs.sv */
// ready flag, read value and target location registers of the nvm controller
// assumes avalon-mm master on ref_clk_in and a busy level from the programming engine
//
// Contract
// - enable bit zero arms ready interrupt
// - ready request is flag and enable level
// - flag held set while not programming
// - write one clears flag, zero keeps
// - data holds last read, software writable
// - eeprom uses only low data byte
// - data low and high byte locations
// - address three byte locations
// - busy reads one during programming
//
// map: 0x00 enable, 0x04 flag byte with the data pair at 0x06 and 0x07,
// 0x08 location bytes 0x08 to 0x0A, 0x10 sticky events, 0x14 event mask
// every read and write waits exactly one cycle; read data are loaded when
// the request is accepted, so they stand while waitrequest is low
// limitation: a write of one to the flag while idle is lost, because the
// idle level sets the flag in the same cycle and the set wins
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module nrd_regs
    import nrd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic prog_busy_in,
    input wire logic read_done_in,
    input wire logic eeprom_read_in,
    input wire logic [15:0] read_value_in,
    output logic ready_irq_out,
    output logic event_irq_out,
    output logic [23:0] target_location_out
);
    // =====================================================
    // bus slave: one wait cycle, answer on second cycle
    nrd_req_type req;
    nrd_state_type state_reg;
    nrd_state_type state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wait_reg;
    logic wait_next;
    logic take; // request answered this edge, one cycle after acceptance
    assign req = '{rd: avs_read, wr: avs_write, addr: avs_address,
                   be: avs_byteenable, wdata: avs_writedata};
    assign take = (state_reg == NRD_ANSWER);

    // address decode helper, used by write and read paths
    // byte offsets inside one 32-bit word share a decode; byte enables pick the lane
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // =====================================================
    // state registers
    logic irq_en_reg; // ready interrupt enable
    logic irq_en_next;
    logic flag_reg; // idle flag
    logic flag_next;
    logic busy_reg; // registered busy level
    logic [NRD_EV_W-1:0] stat_reg; // sticky events
    logic [NRD_EV_W-1:0] stat_next;
    logic [NRD_EV_W-1:0] mask_reg;
    logic [NRD_EV_W-1:0] mask_next;
    logic ready_irq_reg;
    logic event_irq_reg;
    logic [15:0] data_q;
    logic [23:0] addr_q;
    logic wr_take;
    logic rd_take;
    logic [NRD_EV_W-1:0] ev;
    assign wr_take = take && req.wr;
    // reads load their data at acceptance, so the word stands during the answer
    assign rd_take = (state_reg == NRD_IDLE) && req.rd;
    // busy edges are the events
    assign ev[NRD_EV_READY] = busy_reg && !prog_busy_in;
    assign ev[NRD_EV_START] = !busy_reg && prog_busy_in;

    // =====================================================
    // data register: capture of read results wins over software
    nrd_bytereg #(.BYTES(2), .RST(NRD_DATA_RST)) u_data (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_take && hit(req.addr, NRD_DATA_OFS)),
        // the pair sits in the upper lanes of its word, so shift the lanes down
        .be_in(4'(req.be >> NRD_DATA_OFS[1:0])),
        .wdata_in(32'(req.wdata >> (8 * NRD_DATA_OFS[1:0]))),
        .cap_in(read_done_in),
        // eeprom reads fill only the low byte, upper kept as is
        .cap_data_in(eeprom_read_in ? {data_q[15:8], read_value_in[7:0]}
                                    : read_value_in),
        .q_out(data_q)
    );
    // address register, three byte lanes
    nrd_bytereg #(.BYTES(3), .RST(NRD_ADDR_RST)) u_addr (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_take && hit(req.addr, NRD_ADDR_OFS)),
        .be_in(req.be),
        .wdata_in(req.wdata),
        .cap_in(1'b0),
        .cap_data_in(NRD_ADDR_RST),
        .q_out(addr_q)
    );

    // =====================================================
    // control next values
    always_comb begin
        state_next = take ? NRD_IDLE : ((req.rd || req.wr) ? NRD_ANSWER : NRD_IDLE);
        wait_next = !((req.rd || req.wr) && state_reg == NRD_IDLE);
        irq_en_next = irq_en_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        // flag tracks idle: set while idle, low while programming
        flag_next = !prog_busy_in;
        rdata_next = rdata_reg;
        if (wr_take && req.be[0]) begin
            if (hit(req.addr, NRD_CTRL_OFS)) begin
                // software arms or disarms; handler disarms it
                irq_en_next = req.wdata[NRD_READY_BIT];
            end
            if (hit(req.addr, NRD_MASK_OFS)) begin
                mask_next = req.wdata[NRD_EV_W-1:0];
            end
            // write one clears, but idle hardware set wins
            if (hit(req.addr, NRD_FLAG_OFS) && req.wdata[NRD_READY_BIT]
                && prog_busy_in) begin
                flag_next = 1'b0;
            end
        end
        if (rd_take) begin
            unique case (1'b1)
                hit(req.addr, NRD_CTRL_OFS): rdata_next = {31'h0, irq_en_reg};
                hit(req.addr, NRD_FLAG_OFS): begin
                    // flag byte and the data pair share one word
                    rdata_next = NRD_UNMAPPED;
                    rdata_next[NRD_READY_BIT] = flag_reg;
                    rdata_next[NRD_BUSY_BIT] = busy_reg;
                    rdata_next[8*NRD_DATA_OFS[1:0] +: 16] = data_q;
                end
                hit(req.addr, NRD_ADDR_OFS): rdata_next = {8'h0, addr_q};
                hit(req.addr, NRD_STAT_OFS): rdata_next = {30'h0, stat_reg};
                hit(req.addr, NRD_MASK_OFS): rdata_next = {30'h0, mask_reg};
                default: rdata_next = NRD_UNMAPPED;
            endcase
            // read clears status; new events still land
            if (hit(req.addr, NRD_STAT_OFS)) begin
                stat_next = NRD_EV_RST;
            end
        end
        stat_next = stat_next | ev;
    end

    // =====================================================
    // registers only
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= NRD_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= NRD_UNMAPPED;
            irq_en_reg <= 1'b0;
            flag_reg <= 1'b0;
            busy_reg <= 1'b0;
            stat_reg <= NRD_EV_RST;
            mask_reg <= NRD_EV_RST;
            ready_irq_reg <= 1'b0;
            event_irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            irq_en_reg <= irq_en_next;
            flag_reg <= flag_next;
            busy_reg <= prog_busy_in;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            // level request; software must arm only after a command
            ready_irq_reg <= flag_next && irq_en_next;
            event_irq_reg <= |(stat_next & mask_next);
        end
    end

    assign avs_readdata_out = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign ready_irq_out = ready_irq_reg;
    assign event_irq_out = event_irq_reg;
    assign target_location_out = addr_q;

    // =====================================================
    // checks
    // the first edge after reset still shows the reset flag, so start one later
    sequence idle_two_s;
        !$past(rst_in) && !prog_busy_in ##1 !prog_busy_in;
    endsequence
    ready_level_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ready_irq_out == (flag_reg && irq_en_reg))
        else $error("ready request not flag and enable");
    flag_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        idle_two_s |-> flag_reg)
        else $error("flag clear while idle");
    flag_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (!$past(rst_in) && !flag_reg && !prog_busy_in) |=> flag_reg)
        else $error("flag not restored when idle");
    flag_keep_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && req.be[NRD_FLAG_OFS[1:0]] && hit(req.addr, NRD_FLAG_OFS)
        && !req.wdata[NRD_READY_BIT]) |=> flag_reg == !$past(prog_busy_in))
        else $error("flag changed by a write of zero");
    enable_wr_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && req.be[0] && hit(req.addr, NRD_CTRL_OFS))
        |=> irq_en_reg == $past(req.wdata[NRD_READY_BIT]))
        else $error("enable write lost");
    data_cap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (read_done_in && !eeprom_read_in) |=> data_q == $past(read_value_in))
        else $error("read value not captured");
    data_high_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (read_done_in && eeprom_read_in) |=> $stable(data_q[15:8]))
        else $error("eeprom read touched high byte");
    addr_lane_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && hit(req.addr, NRD_ADDR_OFS) && req.be[2])
        |=> addr_q[23:16] == $past(req.wdata[23:16]))
        else $error("address extended byte not written");
    busy_read_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_take && hit(req.addr, NRD_FLAG_OFS))
        |=> avs_readdata_out[NRD_BUSY_BIT] == $past(busy_reg))
        else $error("busy bit misread");
    wait_answer_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ($rose(avs_read) && avs_waitrequest_out) |-> ##[1:2] !avs_waitrequest_out)
        else $error("no bus answer");

    // =====================================================
    // flag and request levels while programming
    flag_busy_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        prog_busy_in |=> !flag_reg)
        else $error("flag set while programming");
    ready_off_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (irq_en_reg && prog_busy_in) |=> !ready_irq_out)
        else $error("ready request during programming");

    // =====================================================
    // data pair lanes: low byte at the base, high byte one above
    data_lane_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && hit(req.addr, NRD_DATA_OFS) && req.be[NRD_DATA_OFS[1:0]] && !read_done_in)
        |=> data_q[7:0] == $past(req.wdata[8*NRD_DATA_OFS[1:0] +: 8]))
        else $error("data low byte not written");
    data_upper_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_take && hit(req.addr, NRD_DATA_OFS) && req.be[NRD_DATA_OFS[1:0] + 1]
        && !read_done_in)
        |=> data_q[15:8] == $past(req.wdata[8*NRD_DATA_OFS[1:0] + 8 +: 8]))
        else $error("data high byte not written");

    // =====================================================
    // bus answer: accepted request is answered for exactly one cycle
    sequence accept_s;
        (avs_read || avs_write) && state_reg == NRD_IDLE;
    endsequence
    sequence answer_s;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    ask_answer_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        accept_s |=> answer_s)
        else $error("answer not one cycle after accept");
    wait_one_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");

    // =====================================================
    // event status: a new event beats a clearing read
    stat_set_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ev[NRD_EV_READY] |=> stat_reg[NRD_EV_READY])
        else $error("finish event lost");
    event_level_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        event_irq_out == |(stat_reg & mask_reg))
        else $error("event request not status and mask");
endmodule
